// [inc/wwdp_params.svh]
`ifndef WWDP_PARAMS_SVH
`define WWDP_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define WWDP_OFF_CTRL_A    12'h000
`define WWDP_OFF_LOAD_A    12'h004
`define WWDP_OFF_WIN_A     12'h008
`define WWDP_OFF_CNT_A     12'h00c
`define WWDP_OFF_CTRL_B    12'h010
`define WWDP_OFF_LOAD_B    12'h014
`define WWDP_OFF_WIN_B     12'h018
`define WWDP_OFF_CNT_B     12'h01c
`define WWDP_OFF_FEED      12'h020
`define WWDP_OFF_STAT      12'h024
`define WWDP_OFF_MASK      12'h028

// ----------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------
`define WWDP_CTL_EN        0
`define WWDP_CTL_WIN       1
`define WWDP_CTL_SRC_LO    2
`define WWDP_CTL_PRE_LO    4
`define WWDP_CTL_PRE_W     4

// ----------------------------------------------------------------------
// Feed key and status bits
// ----------------------------------------------------------------------
`define WWDP_FEED_KEY      16'ha5a5
`define WWDP_FEED_A_BIT    16
`define WWDP_FEED_B_BIT    17
`define WWDP_ST_EXP_A      0
`define WWDP_ST_EXP_B      1
`define WWDP_ST_BADF_A     2
`define WWDP_ST_BADF_B     3

`define WWDP_LOAD_RST      32'hffffffff
`define WWDP_SLVERR        2'b10
`define WWDP_OKAY          2'b00

`endif

// [inc/wwdp_pkg.sv]
package wwdp_pkg;
  typedef enum logic [1:0]
  {
    WWDP_SRC_SYS,
    WWDP_SRC_RTC,
    WWDP_SRC_PM
  } wwdp_src_e;
endpackage

// [rtl/wwdp_top.sv]
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "wwdp_params.svh"

// Operation
// - Two watchdogs, each with own enable, timing and window mode.
// - 32-bit counter, behind a programmable prescaler on the system clock only; expiry resets system.
// - Missed feed in the timing window is a timeout causing reset.
// - Cause flag of the expired watchdog survives the system reset.
// - Counting clock selectable: scaled system, real-time, power-management.
module wwdp_top
  import wwdp_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              por_n,
  input  wire logic              clk_en,
  input  wire logic              rtc_tick,
  input  wire logic              pm_tick,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   wdt_reset_req,
  output logic                   irq
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [31:0]       ctrl [2], load [2], win [2], cnt [2];
  logic [15:0]       pre [2];
  logic [3:0]        stat, mask, ws_q;
  logic [1:0]        cause;
  logic              aw_hold, w_hold;
  logic [ADDR_W-1:0] aw_q;
  logic [31:0]       wd_q;
  logic [31:0]       next_ctrl [2], next_load [2], next_win [2];
  logic [31:0]       next_cnt [2], next_wd_q, next_rdata;
  logic [15:0]       next_pre [2];
  logic [3:0]        next_stat, next_mask, next_ws_q;
  logic [1:0]        next_cause, next_bresp, next_rresp;
  logic              next_aw_hold, next_w_hold, next_bvalid, next_rvalid;
  logic              next_rst_req, next_irq;
  logic [ADDR_W-1:0] next_aw_q;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (nw & m) | (old & ~m);
  endfunction

  function automatic logic tick_of(input logic [31:0] c, input logic [15:0] p,
                                   input logic rt, input logic pm);
    logic [1:0] s;
    s = c[`WWDP_CTL_SRC_LO +: 2];
    return (s == 2'(WWDP_SRC_RTC)) ? rt
         : (s == 2'(WWDP_SRC_PM)) ? pm : (p == 16'h0000);
  endfunction

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb
  begin
    logic        wr, rd, feed_ok, hit, tk;
    logic [1:0]  feed_req;
    logic [3:0]  ev;
    logic [31:0] pmax;
    wr = 1'b0;
    rd = 1'b0;
    feed_ok = 1'b0;
    feed_req = 2'b00;
    ev = 4'h0;
    hit = 1'b1;
    pmax = 32'h0;
    tk = 1'b0;
    next_ctrl = ctrl;
    next_load = load;
    next_win = win;
    next_cnt = cnt;
    next_pre = pre;
    next_mask = mask;
    next_cause = cause;
    next_aw_hold = aw_hold;
    next_w_hold = w_hold;
    next_aw_q = aw_q;
    next_wd_q = wd_q;
    next_ws_q = ws_q;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    next_rst_req = 1'b0;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_hold = 1'b1;
      next_aw_q = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_hold = 1'b1;
      next_wd_q = s_axi_wdata;
      next_ws_q = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready)
      next_bvalid = 1'b0;
    wr = aw_hold && w_hold && !s_axi_bvalid;
    if (wr)
    begin
      next_aw_hold = 1'b0;
      next_w_hold = 1'b0;
      next_bvalid = 1'b1;
      if (aw_q == `WWDP_OFF_CTRL_A)
        next_ctrl[0] = merge(ctrl[0], wd_q, ws_q);
      else if (aw_q == `WWDP_OFF_LOAD_A)
        next_load[0] = merge(load[0], wd_q, ws_q);
      else if (aw_q == `WWDP_OFF_WIN_A)
        next_win[0] = merge(win[0], wd_q, ws_q);
      else if (aw_q == `WWDP_OFF_CTRL_B)
        next_ctrl[1] = merge(ctrl[1], wd_q, ws_q);
      else if (aw_q == `WWDP_OFF_LOAD_B)
        next_load[1] = merge(load[1], wd_q, ws_q);
      else if (aw_q == `WWDP_OFF_WIN_B)
        next_win[1] = merge(win[1], wd_q, ws_q);
      else if (aw_q == `WWDP_OFF_FEED)
      begin
        // Key guards against a stray store feeding the dog
        feed_ok = (ws_q == 4'hf) && (wd_q[15:0] == `WWDP_FEED_KEY);
        feed_req = {wd_q[`WWDP_FEED_B_BIT], wd_q[`WWDP_FEED_A_BIT]};
      end
      else if (aw_q == `WWDP_OFF_STAT)
      begin
        if (ws_q[0])
          next_cause = cause & ~wd_q[5:4];
      end
      else if (aw_q == `WWDP_OFF_MASK)
      begin
        if (ws_q[0])
          next_mask = wd_q[3:0];
      end
      else if (aw_q != `WWDP_OFF_CNT_A && aw_q != `WWDP_OFF_CNT_B)
        hit = 1'b0;
      next_bresp = hit ? `WWDP_OKAY : `WWDP_SLVERR;
    end
    for (int i = 0; i < 2; i++)
    begin
      pmax = 32'h1 << ctrl[i][`WWDP_CTL_PRE_LO +: `WWDP_CTL_PRE_W];
      next_pre[i] = (pre[i] == 16'h0000) ? 16'(pmax - 32'h1)
                                          : pre[i] - 16'h0001;
      tk = tick_of(ctrl[i], pre[i], rtc_tick, pm_tick);
      if (!ctrl[i][`WWDP_CTL_EN])
      begin
        next_cnt[i] = load[i];
        next_pre[i] = 16'h0000;
      end
      else if (feed_ok && feed_req[i])
      begin
        if (ctrl[i][`WWDP_CTL_WIN] && cnt[i] > win[i])
        begin
          ev[2+i] = 1'b1;
          next_rst_req = 1'b1;
          next_cause[i] = 1'b1;
        end
        next_cnt[i] = load[i];
      end
      else if (tk)
      begin
        if (cnt[i] == 32'h0)
        begin
          ev[i] = 1'b1;
          next_rst_req = 1'b1;
          next_cause[i] = 1'b1;
          next_cnt[i] = load[i];
        end
        else
          next_cnt[i] = cnt[i] - 32'h1;
      end
    end
    // Hardware set wins over write-one-to-clear
    next_stat = stat;
    if (wr && aw_q == `WWDP_OFF_STAT && ws_q[0])
      next_stat = stat & ~wd_q[3:0];
    next_stat = next_stat | ev;
    next_irq = |(next_stat & next_mask);
    if (s_axi_rvalid && s_axi_rready)
      next_rvalid = 1'b0;
    rd = s_axi_arvalid && s_axi_arready;
    if (rd)
    begin
      next_rvalid = 1'b1;
      next_rresp = `WWDP_OKAY;
      next_rdata = 32'h0;
      if (s_axi_araddr == `WWDP_OFF_CTRL_A)
        next_rdata = ctrl[0];
      else if (s_axi_araddr == `WWDP_OFF_LOAD_A)
        next_rdata = load[0];
      else if (s_axi_araddr == `WWDP_OFF_WIN_A)
        next_rdata = win[0];
      else if (s_axi_araddr == `WWDP_OFF_CNT_A)
        next_rdata = cnt[0];
      else if (s_axi_araddr == `WWDP_OFF_CTRL_B)
        next_rdata = ctrl[1];
      else if (s_axi_araddr == `WWDP_OFF_LOAD_B)
        next_rdata = load[1];
      else if (s_axi_araddr == `WWDP_OFF_WIN_B)
        next_rdata = win[1];
      else if (s_axi_araddr == `WWDP_OFF_CNT_B)
        next_rdata = cnt[1];
      else if (s_axi_araddr == `WWDP_OFF_STAT)
        next_rdata = {26'h0, cause, stat};
      else if (s_axi_araddr == `WWDP_OFF_MASK)
        next_rdata = {28'h0, mask};
      else if (s_axi_araddr != `WWDP_OFF_FEED)
        next_rresp = `WWDP_SLVERR;
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!por_n)
      cause <= 2'b00;
    else if (clk_en)
      cause <= next_cause;
    if (!aresetn)
    begin
      ctrl <= '{default: 32'h0};
      load <= '{default: `WWDP_LOAD_RST};
      win <= '{default: 32'h0};
      cnt <= '{default: `WWDP_LOAD_RST};
      pre <= '{default: 16'h0};
      stat <= 4'h0;
      mask <= 4'h0;
      // Payload holders need no reset: the hold flags qualify them
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'b00;
      wdt_reset_req <= 1'b0;
      irq <= 1'b0;
    end
    else if (clk_en)
    begin
      ctrl <= next_ctrl;
      load <= next_load;
      win <= next_win;
      cnt <= next_cnt;
      pre <= next_pre;
      stat <= next_stat;
      mask <= next_mask;
      aw_hold <= next_aw_hold;
      w_hold <= next_w_hold;
      aw_q <= next_aw_q;
      wd_q <= next_wd_q;
      ws_q <= next_ws_q;
      s_axi_awready <= !next_aw_hold && !s_axi_awready;
      s_axi_wready <= !next_w_hold && !s_axi_wready;
      s_axi_arready <= !next_rvalid && !s_axi_arready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
      wdt_reset_req <= next_rst_req;
      irq <= next_irq;
    end
  end

endmodule

// [tb/tb_wwdp_top.sv]
`timescale 1ns/1ps
`include "wwdp_params.svh"
module tb_wwdp_top
  import wwdp_pkg::*;
;
  logic        aclk = 0, rst_n = 0, fb_on = 1, por_n = 0;
  logic        clk_en = 1, rtc_tick = 0, pm_tick = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, wdt_reset_req, irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  int          miscompares = 0, checks_done = 0, cyc = 0, pulses = 0;
  int          seed = 32'h6ed4, ld, k, p0, expv;
  // Expiry request loops back as system reset, except where masked off
  wire         aresetn = rst_n && !(fb_on && wdt_reset_req);

  wwdp_top i_wwdp_top (.aclk, .aresetn, .por_n, .clk_en, .rtc_tick,
    .pm_tick, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .wdt_reset_req, .irq);

  always #25 aclk = ~aclk;

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    int n;
    logic pa, pw;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    pa = 1;
    pw = 1;
    for (n = 0; n < 200; n++)
    begin
      @(posedge aclk);
      if (pa && s_axi_awready)
      begin
        s_axi_awvalid <= 0;
        pa = 0;
      end
      if (pw && s_axi_wready)
      begin
        s_axi_wvalid <= 0;
        pw = 0;
      end
      if (!pa && !pw && s_axi_bvalid === 1'b1)
        break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 0;
  endtask

  task automatic rd(input logic [11:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (n = 0; n < 200; n++)
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 0;
      if (s_axi_rvalid === 1'b1)
        break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int src, input int n);
    repeat (n)
    begin
      @(posedge aclk);
      if (src == 1) rtc_tick <= 1; else pm_tick <= 1;
      @(posedge aclk);
      rtc_tick <= 0;
      pm_tick <= 0;
      repeat (3) @(posedge aclk);
    end
  endtask

  // Ticks until a reset request is seen, bounded
  task automatic expire(input int src, input int max);
    p0 = pulses;
    for (k = 0; k < max && pulses == p0; k++)
      tick(src, 1);
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  always @(posedge aclk)
  begin
    cyc++;
    if (wdt_reset_req === 1'b1) pulses++;
    if (cyc == 20000)
    begin
      miscompares++;
      give_verdict;
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge aclk);
    rst_n <= 1;
    por_n <= 1;
    rd(`WWDP_OFF_LOAD_A);
    chk(d, `WWDP_LOAD_RST);
    rd(12'h030);
    chk({r, d[29:0]}, {`WWDP_SLVERR, 30'h0});
    wr(12'h030, 32'h0);
    chk(32'(r), 32'(`WWDP_SLVERR));
    ld = 4 + ($random(seed) & 7);
    expv = ld + 1;
    wr(`WWDP_OFF_LOAD_A, ld);
    chk(32'(r), 32'(`WWDP_OKAY));
    rd(`WWDP_OFF_CNT_A);
    chk(d, ld);
    wr(`WWDP_OFF_CTRL_A, 32'({WWDP_SRC_RTC, 2'b01}));
    expire(1, 20);
    chk(k, expv);
    rd(`WWDP_OFF_STAT);
    chk(d & 32'h30, 32'h10);
    wr(`WWDP_OFF_STAT, 32'h30);
    wr(`WWDP_OFF_LOAD_B, 32'h8);
    wr(`WWDP_OFF_CTRL_B, 32'({WWDP_SRC_PM, 2'b01}));
    tick(2, 6);
    wr(`WWDP_OFF_FEED, 32'h2a5a5);
    tick(2, 6);
    // Ticks while frozen must not count
    clk_en <= 0;
    tick(2, 4);
    clk_en <= 1;
    expire(2, 10);
    chk(k, 3);
    rd(`WWDP_OFF_STAT);
    chk(d & 32'h30, 32'h20);
    wr(`WWDP_OFF_STAT, 32'h30);
    fb_on <= 0;
    wr(`WWDP_OFF_MASK, 32'hf);
    wr(`WWDP_OFF_LOAD_A, 32'h8);
    wr(`WWDP_OFF_WIN_A, 32'h3);
    wr(`WWDP_OFF_CTRL_A, 32'({WWDP_SRC_RTC, 2'b11}));
    tick(1, 6);
    p0 = pulses;
    wr(`WWDP_OFF_FEED, 32'h1a5a5);
    repeat (4) @(posedge aclk);
    chk(pulses - p0, 0);
    wr(`WWDP_OFF_FEED, 32'h1a5a5);
    repeat (4) @(posedge aclk);
    chk(pulses - p0, 1);
    chk(irq, 1);
    rd(`WWDP_OFF_STAT);
    chk(d & 32'h3f, 32'h14);
    wr(`WWDP_OFF_STAT, 32'h34);
    wr(`WWDP_OFF_MASK, 32'h0);
    wr(`WWDP_OFF_FEED, 32'h1a5a5);
    repeat (4) @(posedge aclk);
    chk(irq, 0);
    rd(`WWDP_OFF_STAT);
    chk(d & 32'h4, 32'h4);
    wr(`WWDP_OFF_CTRL_A, 32'h0);
    wr(`WWDP_OFF_STAT, 32'h34);
    fb_on <= 1;
    // Prescaler is held at zero while disabled, so its phase is fixed; allow 6 cycles early, 8 late
    expv = (8 + 1) << 2;
    // Load value was lost in the earlier watchdog reset
    wr(`WWDP_OFF_LOAD_B, 32'h8);
    wr(`WWDP_OFF_CTRL_B, 32'h21);
    p0 = pulses;
    for (k = 0; k < 100 && pulses == p0; k++)
      @(posedge aclk);
    chk(k >= expv - 6 && k <= expv + 8, 1);
    give_verdict;
  end
endmodule

bind wwdp_top wwdp_properties #(.ADDR_W(ADDR_W)) i_wwdp_properties (.aclk,
  .aresetn, .clk_en, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .wdt_reset_req, .irq);

// [tb/wwdp_properties.sv]
`timescale 1ns/1ps
`include "wwdp_params.svh"
module wwdp_properties #(
  parameter int ADDR_W = 12
)
(
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              clk_en,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic              wdt_reset_req,
  input wire logic              irq
);
  // A frozen clock enable stalls everything but the resets, so it pauses checking too
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn || !clk_en);

  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
  a_r_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read answer late");
  a_r_cause: assert property ($rose(s_axi_rvalid)
    |-> $past(s_axi_arvalid && s_axi_arready)) else $error("rvalid unasked");
  a_r_unmapped: assert property (s_axi_arvalid && s_axi_arready
    && s_axi_araddr > `WWDP_OFF_MASK |=> s_axi_rresp == `WWDP_SLVERR
    && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
  a_b_code: assert property (s_axi_bvalid |-> s_axi_bresp inside
    {`WWDP_OKAY, `WWDP_SLVERR}) else $error("bad write response");
  a_req_pulse: assert property (wdt_reset_req |=> !wdt_reset_req)
    else $error("reset request too long");
  a_reset_quiet: assert property (disable iff (!clk_en) !aresetn
    |=> !s_axi_bvalid && !s_axi_rvalid && !irq && !wdt_reset_req)
    else $error("outputs active in reset");
endmodule
